// ---- bench/mds_bb_model.sv ----
// partner: baseband source and clock distributor driving strobes and data
`timescale 1ns/1ps
module mds_bb_model
    import mds_pkg::*;
(
    input  wire logic     clk_i,
    input  wire mds_src_t go_i,
    input  wire logic     stream_i,
    output logic          input_strobe_o,
    output logic          sync_o,
    output logic          output_strobe_o,
    output logic          sample_valid_o,
    output logic [15:0]   sample_o
);
    // idle levels at time zero
    initial begin
        {input_strobe_o, sync_o, output_strobe_o, sample_valid_o} = 4'h0;
        sample_o = 16'h1234;
    end
    // one rising edge per request is enough for any sync
    always @(posedge clk_i) begin
        input_strobe_o <= go_i.input_strobe;
        sync_o <= go_i.sync;
        output_strobe_o <= go_i.output_strobe;
    end
    // data with valid; idle data keeps changing so stale words never look good
    always @(posedge clk_i) begin
        sample_valid_o <= stream_i;
        sample_o <= stream_i ? sample_o + 16'h0001 : ~sample_o;
    end
endmodule

// ---- bench/mds_sync_ctrl_assertions.sv ----
// checker: port-level timing properties of the sync controller
`timescale 1ns/1ps
module mds_chk
    import mds_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        transmit_enable_pin_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [15:0] sample_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic [15:0] sample_o,
    input  wire logic        tx_active_o,
    input  wire logic        data_rate_tick_o,
    input  wire logic        fifo_in_sync_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus request taken, then a single-cycle answer
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_once: assert property (s_req |-> s_ans)
        else $error("bus answer not a single pulse");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    chk_tx_pin: assert property (transmit_enable_pin_i |=> tx_active_o)
        else $error("pin did not start transmit");
    chk_quiet_idle: assert property (!tx_active_o && $past(!tx_active_o) |->
        sample_o == MDS_MIDSCALE) else $error("output not mid-scale while idle");
    chk_data_pass: assert property (tx_active_o && $past(tx_active_o) |->
        sample_o == $past(sample_i)) else $error("sample not passed while on");
    chk_tick_pulse: assert property (data_rate_tick_o |=> !data_rate_tick_o)
        else $error("divider tick longer than a cycle");
    chk_insync_pulse: assert property (fifo_in_sync_o |=> !fifo_in_sync_o)
        else $error("input sync event longer than a cycle");
    chk_tx_hold: assert property ($rose(tx_active_o) |-> ##1 tx_active_o)
        else $error("transmit dropped at once");
endmodule

bind mds_sync_ctrl mds_chk i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .transmit_enable_pin_i(transmit_enable_pin_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .sample_i(sample_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_o(sample_o), .tx_active_o(tx_active_o),
    .data_rate_tick_o(data_rate_tick_o), .fifo_in_sync_o(fifo_in_sync_o));

// ---- bench/testbench.sv ----
// testbench: register, pointer sync and transmit scenarios
`timescale 1ns/1ps
module testbench
    import mds_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, rpin_n = 1'b1, tx_pin = 1'b0, stream = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, txa, fuse, tick, insync;
    logic input_strobe, syn, output_strobe, sval;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [15:0] sdat, dout;
    mds_src_t go = '0;
    mds_ptr_t ptr;
    int error_cnt = 0, checks = 0, ncyc = 0;

    mds_bb_model i_bb (.clk_i(clk), .go_i(go), .stream_i(stream), .input_strobe_o(input_strobe),
        .sync_o(syn), .output_strobe_o(output_strobe), .sample_valid_o(sval), .sample_o(sdat));
    mds_sync_ctrl i_dut (.clk_i(clk), .rst_i(rst), .active_low_reset_pin_n_i(rpin_n),
        .transmit_enable_pin_i(tx_pin), .input_strobe_i(input_strobe), .sync_i(syn),
        .output_strobe_i(output_strobe), .sample_valid_i(sval), .sample_i(sdat), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h3),
        .wb_dat_o(rdat), .wb_ack_o(ack), .sample_o(dout), .tx_active_o(txa),
        .fuse_sleep_o(fuse), .data_rate_tick_o(tick), .fifo_in_sync_o(insync),
        .fifo_ptr_o(ptr));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // compare and count
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) error_cnt++;
        {cyc, stb} <= 2'b00;
    endtask
    // one sync request to the partner
    task automatic pulse(input mds_src_t s);
        @(posedge clk);
        go <= s;
        @(posedge clk);
        go <= '0;
    endtask
    // n samples from the partner
    task automatic feed(input int n);
        @(posedge clk);
        stream <= 1'b1;
        repeat (n) @(posedge clk);
        stream <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // select reset value, read back, unmapped place, fuse bit, reset pin
    task automatic t_regs();
        wb(1'b0, 8'h80, 16'h0); chk("sel_rst", 16'h0, q[15:0]);
        wb(1'b1, 8'h80, 16'h4401); wb(1'b0, 8'h80, 16'h0);
        chk("sel_rw", 16'h4401, q[15:0]);
        wb(1'b1, 8'hfc, 16'hffff); wb(1'b0, 8'hfc, 16'h0);
        chk("unmapped", 16'h0, q[15:0]);
        wb(1'b1, 8'h6c, 16'h0800);
        @(negedge clk);
        chk("fuse", 16'h1, {15'h0, fuse});
        @(posedge clk);
        rpin_n <= 1'b0;
        repeat (3) @(posedge clk);
        rpin_n <= 1'b1;
        @(negedge clk);
        chk("pin_clear", 16'h0, {15'h0, fuse});
    endtask
    // bypassed pll: output strobe aligns divider and pointers; then single mode
    task automatic t_dual();
        wb(1'b1, 8'h00, 16'h0004);
        wb(1'b1, 8'h80, 16'h4401);
        feed(3);
        pulse(3'b100);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("ptr_output_strobe", 16'h0004, {10'h0, ptr});
        chk("tick_aln0", 16'h0000, {15'h0, tick});
        @(negedge clk);
        chk("tick_aln1", 16'h0001, {15'h0, tick});
        wb(1'b1, 8'h14, 16'h0000);
        repeat (8) @(posedge clk);
        wb(1'b0, 8'h14, 16'h0);
        chk("alarm_coll", 16'h0001, q[15:0]);
        wb(1'b1, 8'h00, 16'h0000);
        wb(1'b1, 8'h80, 16'h0000);
        feed(2);
        pulse(3'b100);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("ptr_off", 16'h0002, {13'h0, ptr.wr});
        wb(1'b1, 8'h00, 16'h0006);
        wb(1'b1, 8'h80, 16'h5500);
        feed(3);
        pulse(3'b100);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("wr_no_output_strobe", 16'h0005, {13'h0, ptr.wr});
        pulse(3'b001);
        @(posedge clk);
        @(negedge clk);
        chk("wr_single", 16'h0000, {13'h0, ptr.wr});
        repeat (2) @(negedge clk);
        chk("rd_single", 16'h0004, {13'h0, ptr.rd});
        wb(1'b1, 8'h00, 16'h0002);
    endtask
    // pll dual mode: sync edge aligns the n divider, its strobe resets the pointers
    task automatic t_pll();
        wb(1'b1, 8'h14, 16'h0000);
        wb(1'b1, 8'h60, 16'h0c00);
        wb(1'b1, 8'h00, 16'h0004);
        wb(1'b1, 8'h80, 16'h4401);
        pulse(3'b010);
        wb(1'b1, 8'h60, 16'h0400);
        feed(3);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("pll_wait", 16'h0003, {13'h0, ptr.wr});
        @(negedge clk);
        chk("pll_output_strobe", 16'h0004, {10'h0, ptr});
        wb(1'b0, 8'h14, 16'h0);
        chk("nd_synced", 16'h0001, {15'h0, q[MDS_NSYNC_BIT]});
        wb(1'b1, 8'h00, 16'h0000);
    endtask
    // input sync source codes: strobe, sync, none
    task automatic t_insync();
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, 8'h7c, (i == 2) ? 16'h0000 : 16'h0004 << i);
            pulse((i == 1) ? 3'b010 : 3'b001);
            @(posedge clk);
            @(negedge clk);
            chk("in_sync", {15'h0, i != 2}, {15'h0, insync});
        end
    endtask
    // transmit by pin and by bit, quiet output between
    task automatic t_tx();
        @(posedge clk);
        tx_pin <= 1'b1;
        feed(2);
        @(negedge clk);
        chk("tx_pin", 16'h1, {15'h0, txa});
        @(posedge clk);
        tx_pin <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("quiet", 16'h8000, dout);
        wb(1'b1, 8'h00, 16'h0001);
        feed(2);
        @(negedge clk);
        chk("tx_bit", 16'h1, {15'h0, txa});
        wb(1'b1, 8'h00, 16'h0000);
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        ncyc++;
        if (ncyc == 4000) begin
            error_cnt++;
            stop_test();
        end
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_dual();
        t_pll();
        t_insync();
        t_tx();
        stop_test();
    end
endmodule

// ---- hdl/mds_div.sv ----
// modulo counter divider with synchronous realign
`timescale 1ns/1ps
module mds_div #(
    parameter int DIV = 16
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic clr_i,
    output logic      tick_o
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;

    // count clocks, restart at zero on realign
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_r <= '0;
        end else if (cnt_r == LAST) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign tick_o = (cnt_r == LAST) & ~clr_i;
endmodule

// ---- hdl/mds_edge.sv ----
// rising edge detector for a synchronous input
`timescale 1ns/1ps
module mds_edge (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic lvl_i,
    output logic      rise_o
);
    logic lvl_r;

    // previous level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= lvl_i;
        end
    end

    assign rise_o = lvl_i & ~lvl_r;
endmodule

// ---- hdl/mds_pkg.sv ----
// package: register map, field positions, reset values and carriers for sync control
package mds_pkg;
    // register indexes; byte address is four times the index
    localparam logic [5:0]  MDS_IDX_MAIN    = 6'h00;
    localparam logic [5:0]  MDS_IDX_ALARM   = 6'h05;
    localparam logic [5:0]  MDS_IDX_PLL     = 6'h18;
    localparam logic [5:0]  MDS_IDX_FUSE    = 6'h1b;
    localparam logic [5:0]  MDS_IDX_SRC     = 6'h1f;
    localparam logic [5:0]  MDS_IDX_SEL     = 6'h20;
    // main_control_register fields
    localparam int          MDS_TXEN_BIT    = 0;
    localparam int          MDS_SINGLE_BIT  = 1;
    localparam int          MDS_DIVALN_BIT  = 2;
    // alarm_status_register fields
    localparam int          MDS_COLL_BIT    = 0;
    localparam int          MDS_NSYNC_BIT   = 1;
    // pll_control_register fields
    localparam int          MDS_PLLEN_BIT   = 10;
    localparam int          MDS_NDSYNC_BIT  = 11;
    // reference_fuse_register fields
    localparam int          MDS_FUSE_BIT    = 11;
    // sync_source_register field: fifo input sync source
    localparam int          MDS_FIN_LSB     = 2;
    // sync_select_register fields
    localparam int          MDS_WRSEL_LSB   = 12;
    localparam int          MDS_RDSEL_LSB   = 8;
    localparam int          MDS_CDSEL_BIT   = 0;
    // source bits inside a 3-bit pointer sync select field
    localparam int          MDS_SRC_INPUT_STROBE    = 0;
    localparam int          MDS_SRC_SYNC    = 1;
    localparam int          MDS_SRC_OUTPUT_STROBE    = 2;
    // reset values
    localparam logic [15:0] MDS_MAIN_RST    = 16'h0000;
    localparam logic [15:0] MDS_PLL_RST     = 16'h0000;
    localparam logic [15:0] MDS_FUSE_RST    = 16'h0000;
    localparam logic [15:0] MDS_SRC_RST     = 16'h0000;
    localparam logic [15:0] MDS_SEL_RST     = 16'h0000;
    localparam logic [15:0] MDS_MIDSCALE    = 16'h8000;
    // reset pin least low time
    localparam int          MDS_CLK_MHZ     = 40;
    localparam int          MDS_RSTPIN_NS   = 25;
    localparam int          MDS_RSTPIN_CYC  = (MDS_RSTPIN_NS * MDS_CLK_MHZ + 999) / 1000;
    // one-cycle sync events, one bit per source
    typedef struct packed {
        logic output_strobe;
        logic sync;
        logic input_strobe;
    } mds_src_t;
    // fifo pointer pair
    typedef struct packed {
        logic [2:0] wr;
        logic [2:0] rd;
    } mds_ptr_t;
endpackage

// ---- hdl/mds_sync_ctrl.sv ----
// multi-device sync and start-up control with a wishbone register file
`timescale 1ns/1ps
module mds_sync_ctrl
    import mds_pkg::*;
#(
    parameter int N_DIV    = 16,
    parameter int CLK_DIV  = 2,
    parameter int RD_START = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        active_low_reset_pin_n_i,
    input  wire logic        transmit_enable_pin_i,
    input  wire logic        input_strobe_i,
    input  wire logic        sync_i,
    input  wire logic        output_strobe_i,
    input  wire logic        sample_valid_i,
    input  wire logic [15:0] sample_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [15:0]      sample_o,
    output logic             tx_active_o,
    output logic             fuse_sleep_o,
    output logic             data_rate_tick_o,
    output logic             fifo_in_sync_o,
    output mds_ptr_t         fifo_ptr_o
);
    localparam logic [2:0] RD_INIT = 3'(RD_START);

    // registers
    logic [15:0] main_r;
    logic [15:0] pll_r;
    logic [15:0] fuse_r;
    logic [15:0] src_r;
    logic [15:0] sel_r;
    logic [1:0]  alarm_r;
    logic [15:0] wmask;
    logic        ack_r;
    logic        wr_en;
    logic        pin_rst;
    logic [3:0]  low_cnt_r;
    logic [5:0]  idx;

    // sync path
    mds_src_t    ev;
    logic        output_strobe_ext_r;
    logic        output_strobe_int;
    logic        input_strobe_rise;
    logic        sync_rise;
    logic        output_strobe_rise;
    logic        nd_clr;
    logic        cd_clr;
    logic        cd_src;
    logic        single_mode;
    logic        wr_rst;
    logic        rd_rst_dual;
    logic        rd_meta_r;
    logic        rd_xfer_r;
    logic        rd_rst;
    logic [2:0]  wr_ptr_r;
    logic [2:0]  rd_ptr_r;
    logic [2:0]  wr_nxt;
    logic [2:0]  rd_nxt;
    logic        coll;
    logic        tx_on;
    logic        fin_sync;

    // register index from the byte address, byte-lane write mask
    assign idx   = wb_adr_i[7:2];
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // a write lands on the edge where the master sees ack
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

    // wishbone ack: one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
        end
    end
    // ack straight from its flip-flop, so it never glitches
    assign wb_ack_o = ack_r;

    // active-low reset pin must stay low the least pulse time to act
    always_ff @(posedge clk_i) begin
        if (rst_i || active_low_reset_pin_n_i) begin
            low_cnt_r <= '0;
        end else if (low_cnt_r != 4'(MDS_RSTPIN_CYC)) begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end
    // pin reset acts once the low time is reached; shorter glitches are ignored
    assign pin_rst = (low_cnt_r == 4'(MDS_RSTPIN_CYC));

    // read data, registered with the ack; unmapped reads as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
            case (idx)
                MDS_IDX_MAIN:  wb_dat_o <= {16'h0000, main_r};
                MDS_IDX_ALARM: wb_dat_o <= {30'h0, alarm_r};
                MDS_IDX_PLL:   wb_dat_o <= {16'h0000, pll_r};
                MDS_IDX_FUSE:  wb_dat_o <= {16'h0000, fuse_r};
                MDS_IDX_SRC:   wb_dat_o <= {16'h0000, src_r};
                MDS_IDX_SEL:   wb_dat_o <= {16'h0000, sel_r};
                default:       wb_dat_o <= '0;
            endcase
        end
    end

    // control registers, byte-lane writes
    always_ff @(posedge clk_i) begin
        if (rst_i || pin_rst) begin
            main_r <= MDS_MAIN_RST;
            pll_r  <= MDS_PLL_RST;
            fuse_r <= MDS_FUSE_RST;
            src_r  <= MDS_SRC_RST;
            sel_r  <= MDS_SEL_RST;
        end else if (wr_en) begin
            case (idx)
                MDS_IDX_MAIN: main_r <= (main_r & ~wmask) | (wb_dat_i[15:0] & wmask);
                MDS_IDX_PLL:  pll_r  <= (pll_r & ~wmask) | (wb_dat_i[15:0] & wmask);
                MDS_IDX_FUSE: fuse_r <= (fuse_r & ~wmask) | (wb_dat_i[15:0] & wmask);
                MDS_IDX_SRC:  src_r  <= (src_r & ~wmask) | (wb_dat_i[15:0] & wmask);
                MDS_IDX_SEL:  sel_r  <= (sel_r & ~wmask) | (wb_dat_i[15:0] & wmask);
                default:      main_r <= main_r;
            endcase
        end
    end
    // fuse sleep control follows its register bit
    assign fuse_sleep_o = fuse_r[MDS_FUSE_BIT];

    // sticky alarms: writing 0 clears a bit, a new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i || pin_rst) begin
            alarm_r <= '0;
        end else begin
            if (wr_en && idx == MDS_IDX_ALARM && wb_sel_i[0]) begin
                alarm_r <= alarm_r & wb_dat_i[1:0];
            end
            if (coll) begin
                alarm_r[MDS_COLL_BIT] <= 1'b1;
            end
            if (nd_clr) begin
                alarm_r[MDS_NSYNC_BIT] <= 1'b1;
            end
        end
    end

    // external output strobe sampled by the converter clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_strobe_ext_r <= 1'b0;
        end else begin
            output_strobe_ext_r <= output_strobe_i;
        end
    end

    // edge detectors on the input strobe and sync sources
    mds_edge u_input_strobe (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .lvl_i  (input_strobe_i),
        .rise_o (input_strobe_rise)
    );
    mds_edge u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .lvl_i  (sync_i),
        .rise_o (sync_rise)
    );

    // pll n divider; a sync edge realigns it, with no tie to the strobes
    assign nd_clr = pll_r[MDS_NDSYNC_BIT] & sync_rise;
    mds_div #(
        .DIV (N_DIV)
    ) u_ndiv (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (nd_clr),
        .tick_o (output_strobe_int)
    );

    // output strobe from pll n divider or from the external pin
    always_comb begin
        output_strobe_rise = output_strobe_ext_r;
        if (pll_r[MDS_PLLEN_BIT]) begin
            output_strobe_rise = output_strobe_int;
        end
    end

    // mode bit: one common source for both pointer resets
    assign single_mode = main_r[MDS_SINGLE_BIT];
    // single mode keeps the output strobe out of pointer sync
    assign ev.input_strobe = input_strobe_rise;
    assign ev.sync = sync_rise;
    assign ev.output_strobe = output_strobe_rise & ~single_mode;

    // clock divider realign: output strobe or input strobe, while enabled
    assign cd_src = sel_r[MDS_CDSEL_BIT] ? output_strobe_rise : input_strobe_rise;
    assign cd_clr = main_r[MDS_DIVALN_BIT] & cd_src;
    mds_div #(
        .DIV (CLK_DIV)
    ) u_cdiv (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (cd_clr),
        .tick_o (data_rate_tick_o)
    );

    // pointer reset sources; an all-zero field never resyncs
    assign wr_rst      = |(sel_r[MDS_WRSEL_LSB +: 3] & ev);
    assign rd_rst_dual = |(sel_r[MDS_RDSEL_LSB +: 3] & ev);

    // fifo input sync: 01 input strobe, 10 sync
    always_comb begin
        case (src_r[MDS_FIN_LSB +: 2])
            2'h1:    fin_sync = input_strobe_rise;
            2'h2:    fin_sync = sync_rise;
            default: fin_sync = 1'b0;
        endcase
    end

    // single mode: read reset is the write reset resampled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_meta_r <= 1'b0;
            rd_xfer_r <= 1'b0;
        end else begin
            rd_meta_r <= wr_rst;
            rd_xfer_r <= rd_meta_r;
        end
    end
    assign rd_rst = single_mode ? rd_xfer_r : rd_rst_dual;

    // pointer advance
    assign wr_nxt = wr_rst ? 3'h0 : (sample_valid_i ? wr_ptr_r + 1'b1 : wr_ptr_r);
    assign rd_nxt = rd_rst ? RD_INIT : (data_rate_tick_o ? rd_ptr_r + 1'b1 : rd_ptr_r);

    // fifo pointers; periodic resync lands on the same phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_r <= 3'h0;
            rd_ptr_r <= RD_INIT;
        end else begin
            wr_ptr_r <= wr_nxt;
            rd_ptr_r <= rd_nxt;
        end
    end

    // collision: pointers meet after a move with no reset that cycle
    assign coll = ~wr_rst & ~rd_rst & (wr_nxt == rd_nxt) &
                  (sample_valid_i | data_rate_tick_o);
    // pointer pair out for the datapath
    assign fifo_ptr_o = '{wr: wr_ptr_r, rd: rd_ptr_r};

    // transmit enable from pin or register bit
    assign tx_on = transmit_enable_pin_i | main_r[MDS_TXEN_BIT];

    // output path, mid-scale while not transmitting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_o       <= MDS_MIDSCALE;
            tx_active_o    <= 1'b0;
            fifo_in_sync_o <= 1'b0;
        end else begin
            sample_o       <= tx_on ? sample_i : MDS_MIDSCALE;
            tx_active_o    <= tx_on;
            fifo_in_sync_o <= fin_sync;
        end
    end
endmodule
